// ### verilog/adc_input_cal_ctrl_consts.vh
// Register indices, byte addresses, field positions, reset values and timing for the input/calibration register bank.
`ifndef ADC_INPUT_CAL_CTRL_CONSTS_VH
`define ADC_INPUT_CAL_CTRL_CONSTS_VH

// Register indices as printed; byte address is four times the index.
`define IDX_TIMESTAMP_INPUT_CONTROL 8'h3b
`define IDX_LANE_PREEMPHASIS_CONTROL 8'h48
`define IDX_ANALOG_INPUT_SELECT 8'h60
`define IDX_CALIBRATION_RUN_ENABLE 8'h61
`define IDX_BANK_STATUS 8'h70

`define ADDR_TIMESTAMP_INPUT_CONTROL 12'h0ec
`define ADDR_LANE_PREEMPHASIS_CONTROL 12'h120
`define ADDR_ANALOG_INPUT_SELECT 12'h180
`define ADDR_CALIBRATION_RUN_ENABLE 12'h184
`define ADDR_BANK_STATUS 12'h1c0

`define RST_TIMESTAMP_INPUT_CONTROL 8'h00
`define RST_LANE_PREEMPHASIS_CONTROL 8'h00
`define RST_ANALOG_INPUT_SELECT 8'h01
`define RST_CALIBRATION_RUN_ENABLE 8'h01

// Field positions.
`define BIT_TIMESTAMP_RECEIVER_ENABLE 0
`define BIT_TIMESTAMP_LVPECL_SELECT 1
`define MSB_PREEMPHASIS_LEVEL 2
`define BIT_PREEMPHASIS_BOOST 3
`define MSB_SINGLE_INPUT_SELECT 1
`define BIT_DUAL_INPUT_SWAP 4
`define BIT_CALIBRATION_ENABLE 0

// Status register bits.
`define BIT_STAT_CAL_RUNNING 0
`define BIT_STAT_CAL_DONE 1
`define BIT_STAT_MUX_PENDING 2
`define BIT_STAT_LINK_BEFORE_CAL 3
`define BIT_STAT_CAL_CLEARED_LINK 4
`define BIT_STAT_SEL_RESERVED 5

// Single-channel input select codes.
`define SEL_RESERVED 2'h0
`define SEL_INPUT_A 2'h1
`define SEL_INPUT_B 2'h2
`define SEL_DUAL_INTERLEAVED 2'h3

`define LANE_COUNT 16
`define CAL_RUN_CYCLES 64

`endif

// ### verilog/input_route_select.v
// Registered routing of the two analog inputs to the two sampling channels.
`timescale 1ns/10ps
`default_nettype none
`include "adc_input_cal_ctrl_consts.vh"

module input_route_select (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire single_mode,
  input wire [1:0] single_sel,
  input wire dual_swap,
  output reg channel_a_from_b,
  output reg channel_b_from_a,
  output reg channel_b_active,
  output reg sel_reserved
);

  // Single-channel modes look only at the select field, dual modes only at the swap bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_a_from_b <= 1'b0;
      channel_b_from_a <= 1'b0;
      channel_b_active <= 1'b1;
      sel_reserved <= 1'b0;
    end else if (load) begin
      if (single_mode) begin
        channel_a_from_b <= (single_sel == `SEL_INPUT_B); // [R7] [R6]
        channel_b_from_a <= 1'b0;
        channel_b_active <= (single_sel == `SEL_DUAL_INTERLEAVED); // [R7]
        sel_reserved <= (single_sel == `SEL_RESERVED);
      end else begin
        channel_a_from_b <= dual_swap; // [R5] [R8]
        channel_b_from_a <= dual_swap; // [R5]
        channel_b_active <= 1'b1;
        sel_reserved <= 1'b0;
      end
    end
  end

endmodule // input_route_select
`default_nettype wire

// ### verilog/calibration_run_ctrl.v
// Calibration run sequencer: held in reset while disabled, runs a fixed length once enabled.
`timescale 1ns/10ps
`default_nettype none
`include "adc_input_cal_ctrl_consts.vh"

module calibration_run_ctrl #(
  parameter RUN_CYCLES = `CAL_RUN_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire cal_enable,
  output wire run_start,
  output reg running,
  output reg done
);

  localparam ST_HELD = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state;
  reg [15:0] count;

  // A run begins on the first cycle the enable is seen high while held.
  assign run_start = (state == ST_HELD) && cal_enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_HELD;
      count <= 16'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else if (!cal_enable) begin
      state <= ST_HELD; // [R10]
      count <= 16'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      case (state)
        ST_HELD: begin
          state <= ST_RUN; // [R10]
          count <= 16'h0000;
          running <= 1'b1;
        end
        ST_RUN: begin
          if (count == RUN_CYCLES - 1) begin
            state <= ST_DONE;
            running <= 1'b0;
            done <= 1'b1;
          end else begin
            count <= count + 16'h0001;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_HELD;
          running <= 1'b0;
          done <= 1'b0;
        end
      endcase
    end
  end

endmodule // calibration_run_ctrl
`default_nettype wire

// ### verilog/adc_input_cal_ctrl_regs.v
// APB register bank for timestamp input, lane pre-emphasis, input mux and calibration enable.
`timescale 1ns/10ps
`default_nettype none
`include "adc_input_cal_ctrl_consts.vh"

// Function
// [R1] Timestamp receiver powered only while bit0 set
// [R2] Bit1 selects low-voltage PECL timestamp input mode
// [R3] One pre-emphasis level drives all sixteen lanes
// [R4] Boost bit raises and lengthens lane pre-emphasis
// [R5] Dual modes: bit4 swaps input A/B routing
// [R6] Swap bit ignored in single-channel modes
// [R7] Single mode field picks A, B or interleaved
// [R8] Single select ignored outside single-channel modes
// [R9] Mux changes apply only after calibration run; here the routing loads when the run starts (run_start)
// [R10] Calibration enable resets high; clear holds calibration
// [R11] Clearing calibration enable resets clock dividers
// [R12] Software clears enable before changing calibration settings
// [R13] Software sets calibration before serial link enable
// [R14] Software clears link enable before calibration
// [R15] Reserved bits store but do nothing
module adc_input_cal_ctrl_regs #(
  parameter LANES = `LANE_COUNT,
  parameter CAL_RUN_CYCLES = `CAL_RUN_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire serial_link_enable,
  input wire link_mode_single,
  output reg timestamp_receiver_enable,
  output reg timestamp_low_voltage_pecl_select,
  output wire [3*LANES-1:0] lane_preemphasis_level,
  output wire [LANES-1:0] lane_preemphasis_boost,
  output wire channel_a_from_b,
  output wire channel_b_from_a,
  output wire channel_b_active,
  output reg calibration_reset,
  output reg clock_divider_reset,
  output wire calibration_running,
  output wire calibration_done
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  localparam SEL_NONE = 3'h0;
  localparam SEL_TSTAMP = 3'h1;
  localparam SEL_PREEMP = 3'h2;
  localparam SEL_INMUX = 3'h3;
  localparam SEL_CALEN = 3'h4;
  localparam SEL_STATUS = 3'h5;

  function [2:0] reg_select;
    input [11:0] addr;
    begin
      case (addr)
        `ADDR_TIMESTAMP_INPUT_CONTROL: reg_select = SEL_TSTAMP;
        `ADDR_LANE_PREEMPHASIS_CONTROL: reg_select = SEL_PREEMP;
        `ADDR_ANALOG_INPUT_SELECT: reg_select = SEL_INMUX;
        `ADDR_CALIBRATION_RUN_ENABLE: reg_select = SEL_CALEN;
        `ADDR_BANK_STATUS: reg_select = SEL_STATUS;
        default: reg_select = SEL_NONE;
      endcase
    end
  endfunction

  reg [7:0] timestamp_input_control;
  reg [7:0] lane_preemphasis_control;
  reg [7:0] analog_input_select;
  reg [7:0] calibration_run_enable;
  reg link_before_cal;
  reg cal_cleared_link;
  reg mux_pending;

  wire [2:0] access_sel;
  wire access_phase;
  wire setup_phase;
  wire wr_en;
  wire lane0_we;
  wire [7:0] status_value;
  wire run_start;
  wire sel_reserved;
  wire cal_enable_bit;

  assign access_sel = reg_select(paddr);
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Zero wait states keep every transfer to exactly one setup and one access cycle.
  assign pready = 1'b1;
  assign pslverr = access_phase && (access_sel == SEL_NONE);
  // Only byte lane 0 carries register data; the upper lanes have nothing to store.
  assign lane0_we = access_phase && pwrite && pstrb[0];
  assign wr_en = lane0_we && (access_sel != SEL_NONE);
  assign cal_enable_bit = calibration_run_enable[`BIT_CALIBRATION_ENABLE];

  // ****************************************************************
  // Writable registers
  // ****************************************************************

  // Reserved bits are kept as written so software reads back its own value.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timestamp_input_control <= `RST_TIMESTAMP_INPUT_CONTROL; // [R1]
      lane_preemphasis_control <= `RST_LANE_PREEMPHASIS_CONTROL;
      analog_input_select <= `RST_ANALOG_INPUT_SELECT; // [R7]
      calibration_run_enable <= `RST_CALIBRATION_RUN_ENABLE; // [R10]
    end else if (wr_en) begin
      case (access_sel)
        SEL_TSTAMP: timestamp_input_control <= pwdata[7:0]; // [R15]
        SEL_PREEMP: lane_preemphasis_control <= pwdata[7:0]; // [R15]
        SEL_INMUX: analog_input_select <= pwdata[7:0]; // [R15]
        SEL_CALEN: calibration_run_enable <= pwdata[7:0]; // [R15]
        default: timestamp_input_control <= timestamp_input_control;
      endcase
    end
  end

  // ****************************************************************
  // Timestamp receiver controls
  // ****************************************************************

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timestamp_receiver_enable <= 1'b0;
      timestamp_low_voltage_pecl_select <= 1'b0;
    end else begin
      timestamp_receiver_enable <= timestamp_input_control[`BIT_TIMESTAMP_RECEIVER_ENABLE]; // [R1]
      timestamp_low_voltage_pecl_select <= timestamp_input_control[`BIT_TIMESTAMP_LVPECL_SELECT]; // [R2]
    end
  end

  // ****************************************************************
  // Lane pre-emphasis fan-out
  // ****************************************************************

  // One flop set per lane keeps the wide fan-out off the register itself.
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      reg [2:0] level;
      reg boost;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level <= 3'h0;
          boost <= 1'b0;
        end else begin
          level <= lane_preemphasis_control[`MSB_PREEMPHASIS_LEVEL:0]; // [R3]
          boost <= lane_preemphasis_control[`BIT_PREEMPHASIS_BOOST]; // [R4]
        end
      end
      assign lane_preemphasis_level[3*lane+2:3*lane] = level;
      assign lane_preemphasis_boost[lane] = boost;
    end
  endgenerate

  // ****************************************************************
  // Calibration enable and resets
  // ****************************************************************

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calibration_reset <= 1'b1;
      clock_divider_reset <= 1'b1;
    end else begin
      calibration_reset <= !cal_enable_bit; // [R10]
      clock_divider_reset <= !cal_enable_bit; // [R11]
    end
  end

  calibration_run_ctrl #(
    .RUN_CYCLES(CAL_RUN_CYCLES)
  ) u_cal_run (
    .pclk(pclk),
    .presetn(presetn),
    .cal_enable(cal_enable_bit),
    .run_start(run_start),
    .running(calibration_running),
    .done(calibration_done)
  );

  // ****************************************************************
  // Input routing, applied at calibration start
  // ****************************************************************

  // The routing is captured only when a calibration run starts, so a new
  // selection never reaches the sampling path with stale calibration.
  input_route_select u_route (
    .pclk(pclk),
    .presetn(presetn),
    .load(run_start), // [R9]
    .single_mode(link_mode_single), // [R6] [R8]
    .single_sel(analog_input_select[`MSB_SINGLE_INPUT_SELECT:0]),
    .dual_swap(analog_input_select[`BIT_DUAL_INPUT_SWAP]),
    .channel_a_from_b(channel_a_from_b),
    .channel_b_from_a(channel_b_from_a),
    .channel_b_active(channel_b_active),
    .sel_reserved(sel_reserved)
  );

  // A write to the mux register leaves the change pending until the next run.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_pending <= 1'b0;
    end else if (wr_en && (access_sel == SEL_INMUX)) begin
      mux_pending <= 1'b1; // [R9]
    end else if (run_start) begin
      mux_pending <= 1'b0; // [R9]
    end
  end

  // ****************************************************************
  // Sequencing checks on software
  // ****************************************************************

  // Sticky flags record ordering slips by software; write one to clear.
  // A new slip in the clearing cycle keeps its flag set.
  wire status_w1c;
  wire link_on_uncal;
  wire cal_dropped_live;

  assign status_w1c = lane0_we && (access_sel == SEL_STATUS);
  assign link_on_uncal = serial_link_enable && !cal_enable_bit; // [R13]
  assign cal_dropped_live = wr_en && (access_sel == SEL_CALEN) &&
                            !pwdata[`BIT_CALIBRATION_ENABLE] && serial_link_enable; // [R14]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_before_cal <= 1'b0;
      cal_cleared_link <= 1'b0;
    end else begin
      if (link_on_uncal) begin
        link_before_cal <= 1'b1; // [R13]
      end else if (status_w1c && pwdata[`BIT_STAT_LINK_BEFORE_CAL]) begin
        link_before_cal <= 1'b0;
      end
      if (cal_dropped_live) begin
        cal_cleared_link <= 1'b1; // [R14]
      end else if (status_w1c && pwdata[`BIT_STAT_CAL_CLEARED_LINK]) begin
        cal_cleared_link <= 1'b0;
      end
    end
  end

  assign status_value = {2'b00, sel_reserved, cal_cleared_link, link_before_cal,
                         mux_pending, calibration_done, calibration_running};

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Read data is captured in the setup cycle so it stands from a flop
  // throughout the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      case (access_sel)
        SEL_TSTAMP: prdata <= {24'h000000, timestamp_input_control};
        SEL_PREEMP: prdata <= {24'h000000, lane_preemphasis_control};
        SEL_INMUX: prdata <= {24'h000000, analog_input_select};
        SEL_CALEN: prdata <= {24'h000000, calibration_run_enable};
        SEL_STATUS: prdata <= {24'h000000, status_value};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // adc_input_cal_ctrl_regs
`default_nettype wire

// ### test/adc_input_cal_ctrl_checker.sv
// Port-level assertions for the input/calibration register bank.
`timescale 1ns/10ps
`default_nettype none
`include "adc_input_cal_ctrl_consts.vh"
module adc_input_cal_ctrl_checker #(
  parameter LANES = 16,
  parameter CAL_RUN_CYCLES = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timestamp_receiver_enable,
  input wire logic timestamp_low_voltage_pecl_select,
  input wire logic [3*LANES-1:0] lane_preemphasis_level,
  input wire logic [LANES-1:0] lane_preemphasis_boost,
  input wire logic channel_a_from_b,
  input wire logic channel_b_from_a,
  input wire logic channel_b_active,
  input wire logic calibration_reset,
  input wire logic clock_divider_reset,
  input wire logic calibration_running,
  input wire logic calibration_done
);
  logic wr;
  logic mapped;
  logic [7:0] run_cnt;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign mapped = paddr == `ADDR_TIMESTAMP_INPUT_CONTROL || paddr == `ADDR_LANE_PREEMPHASIS_CONTROL ||
    paddr == `ADDR_ANALOG_INPUT_SELECT || paddr == `ADDR_CALIBRATION_RUN_ENABLE || paddr == `ADDR_BANK_STATUS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Run length counter
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) run_cnt <= 8'h00;
    else if (!calibration_running) run_cnt <= 8'h00;
    else run_cnt <= run_cnt + 8'h01;
  end
  chk_recv_follow: assert property (wr && paddr == `ADDR_TIMESTAMP_INPUT_CONTROL |-> ##2
    timestamp_receiver_enable == $past(pwdata[0], 2)) else $error("receiver enable does not follow write");
  chk_pecl_follow: assert property (wr && paddr == `ADDR_TIMESTAMP_INPUT_CONTROL |-> ##2
    timestamp_low_voltage_pecl_select == $past(pwdata[1], 2)) else $error("pecl select does not follow write");
  chk_lane_level: assert property (wr && paddr == `ADDR_LANE_PREEMPHASIS_CONTROL |-> ##2
    lane_preemphasis_level == {LANES{$past(pwdata[2:0], 2)}}) else $error("lane level differs from write");
  chk_lane_boost: assert property (wr && paddr == `ADDR_LANE_PREEMPHASIS_CONTROL |-> ##2
    lane_preemphasis_boost == {LANES{$past(pwdata[3], 2)}}) else $error("lane boost differs from write");
  chk_divider_tied: assert property (calibration_reset == clock_divider_reset)
    else $error("divider reset differs from calibration reset");
  chk_cal_hold: assert property (wr && paddr == `ADDR_CALIBRATION_RUN_ENABLE && !pwdata[0] |-> ##2
    calibration_reset && !calibration_running && !calibration_done) else $error("calibration not held");
  chk_run_length: assert property ($fell(calibration_running) && calibration_done |->
    run_cnt == CAL_RUN_CYCLES) else $error("calibration run length wrong");
  chk_route_hold: assert property (!$stable({channel_a_from_b, channel_b_from_a, channel_b_active}) |->
    $rose(calibration_running)) else $error("routing changed outside calibration start");
  chk_bus_error: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("error response wrong");
endmodule // adc_input_cal_ctrl_checker
bind adc_input_cal_ctrl_regs adc_input_cal_ctrl_checker #(.LANES(LANES), .CAL_RUN_CYCLES(CAL_RUN_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .timestamp_receiver_enable(timestamp_receiver_enable),
  .timestamp_low_voltage_pecl_select(timestamp_low_voltage_pecl_select),
  .lane_preemphasis_level(lane_preemphasis_level), .lane_preemphasis_boost(lane_preemphasis_boost),
  .channel_a_from_b(channel_a_from_b), .channel_b_from_a(channel_b_from_a), .channel_b_active(channel_b_active),
  .calibration_reset(calibration_reset), .clock_divider_reset(clock_divider_reset),
  .calibration_running(calibration_running), .calibration_done(calibration_done));
`default_nettype wire

// ### test/adc_input_cal_ctrl_regs_tb.sv
// Self-checking bench for the input/calibration register bank.
`timescale 1ns/10ps
`default_nettype none
`include "adc_input_cal_ctrl_consts.vh"
module adc_input_cal_ctrl_regs_tb;
  localparam LANES = 16;
  logic pclk, presetn, psel, penable, pwrite, serial_link_enable, link_mode_single;
  logic pready, pslverr, ts_en, ts_pecl, afb, bfa, bact, cal_rst, div_rst, running, done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [3*LANES-1:0] lvl;
  logic [LANES-1:0] boost;
  logic [2:0] route;
  int num_errors = 0;
  int cmp_count = 0;
  // Columns of the expectation: single mode, A from B, B from A, B active.
  logic [7:0] mux_tab [6] = '{8'h01, 8'h12, 8'h03, 8'h00, 8'h11, 8'h02};
  logic [3:0] exp_tab [6] = '{4'h8, 4'hc, 4'h9, 4'h8, 4'h7, 4'h1};
  adc_input_cal_ctrl_regs #(.LANES(LANES), .CAL_RUN_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_link_enable(serial_link_enable), .link_mode_single(link_mode_single),
    .timestamp_receiver_enable(ts_en), .timestamp_low_voltage_pecl_select(ts_pecl),
    .lane_preemphasis_level(lvl), .lane_preemphasis_boost(boost), .channel_a_from_b(afb),
    .channel_b_from_a(bfa), .channel_b_active(bact), .calibration_reset(cal_rst),
    .clock_divider_reset(div_rst), .calibration_running(running), .calibration_done(done));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0, 4'h0);
    check(64'({err, rd}), 64'({exp_err, exp}));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Link is dropped before the enable is cleared and raised only after the run ends.
  task automatic recal();
    @(posedge pclk) serial_link_enable <= 1'b0;
    apb(1'b1, `ADDR_CALIBRATION_RUN_ENABLE, 32'h0, 4'h1);
    tick(2);
    check(64'({cal_rst, div_rst, running, done}), 64'hc);
    apb(1'b1, `ADDR_CALIBRATION_RUN_ENABLE, 32'h1, 4'h1);
    for (int n = 0; n < 100 && done !== 1'b1; n++) tick(1);
    check(64'({cal_rst, div_rst, done}), 64'h1);
    @(posedge pclk) serial_link_enable <= 1'b1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    serial_link_enable = 1'b0;
    link_mode_single = 1'b1;
    tick(16);
    check(64'({ts_en, ts_pecl, cal_rst, div_rst}), 64'h3);
    @(posedge pclk) presetn <= 1'b1;
    rdchk(`ADDR_TIMESTAMP_INPUT_CONTROL, 32'h00, 1'b0);
    rdchk(`ADDR_LANE_PREEMPHASIS_CONTROL, 32'h00, 1'b0);
    rdchk(`ADDR_ANALOG_INPUT_SELECT, 32'h01, 1'b0);
    rdchk(`ADDR_CALIBRATION_RUN_ENABLE, 32'h01, 1'b0);
    tick(10);
    check(64'({done, afb, bfa, bact}), 64'h8);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ADDR_TIMESTAMP_INPUT_CONTROL, 32'hfc | i, 4'h1);
      rdchk(`ADDR_TIMESTAMP_INPUT_CONTROL, 32'hfc | i, 1'b0);
      check(64'({ts_pecl, ts_en}), 64'(i));
    end
    apb(1'b1, `ADDR_TIMESTAMP_INPUT_CONTROL, 32'h0, 4'h0);
    rdchk(`ADDR_TIMESTAMP_INPUT_CONTROL, 32'hff, 1'b0);
    rdchk(12'h004, 32'h0, 1'b1);
    $display("test timestamp control done");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `ADDR_LANE_PREEMPHASIS_CONTROL, 32'hf0 | i, 4'h1);
      rdchk(`ADDR_LANE_PREEMPHASIS_CONTROL, 32'hf0 | i, 1'b0);
      check({boost, lvl}, {{LANES{i[3]}}, {LANES{i[2:0]}}});
    end
    $display("test lane pre-emphasis done");
    for (int i = 0; i < 6; i++) begin
      route = {afb, bfa, bact};
      @(posedge pclk) link_mode_single <= exp_tab[i][3];
      apb(1'b1, `ADDR_ANALOG_INPUT_SELECT, 32'(mux_tab[i]), 4'h1);
      rdchk(`ADDR_ANALOG_INPUT_SELECT, 32'(mux_tab[i]), 1'b0);
      tick(3);
      check(64'({afb, bfa, bact}), 64'(route));
      recal();
      check(64'({afb, bfa, bact}), 64'(exp_tab[i][2:0]));
    end
    $display("test input routing done");
    // The status word and its sticky ordering flags are only reachable here.
    rdchk(`ADDR_BANK_STATUS, 32'h02, 1'b0);
    apb(1'b1, `ADDR_CALIBRATION_RUN_ENABLE, 32'h0, 4'h1);
    rdchk(`ADDR_BANK_STATUS, 32'h18, 1'b0);
    @(posedge pclk) serial_link_enable <= 1'b0;
    apb(1'b1, `ADDR_BANK_STATUS, 32'h18, 4'h1);
    rdchk(`ADDR_BANK_STATUS, 32'h00, 1'b0);
    apb(1'b1, `ADDR_CALIBRATION_RUN_ENABLE, 32'h1, 4'h1);
    tick(10);
    check(64'({cal_rst, div_rst, done}), 64'h1);
    $display("test status flags done");
    stop_test();
  end
endmodule // adc_input_cal_ctrl_regs_tb
`default_nettype wire
